// ==== hdl/adsps_top.sv ====
// Power shutdown control of a serial successive approximation converter.
`timescale 1ns/10ps
`default_nettype none
`include "adsps_cfg.svh"
module adsps_top
	import adsps_pkg::*;
#(
	parameter int FRAME_SCLKS = `ADSPS_FRAME_SCLKS,
	parameter int DUMMY_TICKS = `ADSPS_DUMMY_TICKS,
	parameter int ACLK_DIV = `ADSPS_ACLK_DIV
)
(
	input wire logic mclk, // System clock, 125 MHz.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic cs_n, // Chip select pin, active low.
	input wire logic sclk, // Shift clock pin from the host.
	input wire logic din, // Serial command data pin.
	output logic powered_up, // Analog core powered.
	output logic dummy_busy, // Dummy conversion running.
	output logic asleep, // Shut down, waiting for a request.
	output logic conv_start, // One-cycle pulse per conversion request.
	output logic [7:0] cmd_word // Last command word shifted in.
);
	// The frame counter is five bits wide and the tick counters are eight bits wide.
	generate
		if (FRAME_SCLKS < `ADSPS_SHUTDOWN_EDGE || FRAME_SCLKS > 31)
			$error("FRAME_SCLKS out of range");
		if (DUMMY_TICKS < 1 || DUMMY_TICKS > 256)
			$error("DUMMY_TICKS out of range");
		if (ACLK_DIV < 2 || ACLK_DIV > 256)
			$error("ACLK_DIV out of range");
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Link pins are synchronised and turned into one-cycle edge strobes.
	adsps_link_if lnk ();

	adsps_link_sampler u_sampler (
		.mclk(mclk),
		.resetn(resetn),
		.cs_n_pin(cs_n),
		.sclk_pin(sclk),
		.din_pin(din),
		.lnk(lnk)
	);

	////////////////////////////////////////////////////////////////////////////
	adsps_core_type r_r;
	adsps_core_type r_nxt;
	logic tick;
	logic request;
	logic shut_code;
	logic tenth_fall;

	// A free-running divider gives one tick per ACLK_DIV cycles to clock the dummy conversion.
	assign tick = (r_r.div_cnt == 8'(ACLK_DIV - 1));
	// The two word length select bits sit at the bottom of the command word.
	assign shut_code = ({r_r.cmd[`ADSPS_WL_HI_BIT], r_r.cmd[`ADSPS_WL_LO_BIT]} == `ADSPS_SHUTDOWN_WL);
	assign tenth_fall = lnk.sclk_fall && (r_r.bit_cnt == 5'(`ADSPS_SHUTDOWN_EDGE - 1));
	// A falling chip select, or resumed shift clocks with chip select held low.
	assign request = lnk.cs_fall || (!lnk.cs_n && lnk.sclk_rise);

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.conv_start = 1'b0;
		r_nxt.div_cnt = tick ? 8'h00 : r_r.div_cnt + 8'h01;
		unique case (r_r.state)
			ADSPS_IDLE, ADSPS_SLEEP:
			begin
				// A request always starts a new frame and powers the core at once.
				if (request)
				begin
					r_nxt.state = ADSPS_SHIFT;
					r_nxt.powered = 1'b1;
					r_nxt.conv_start = 1'b1;
					r_nxt.bit_cnt = 5'h00;
					// When shift clocks wake the block, the waking edge carries the first bit.
					r_nxt.cmd = lnk.cs_fall ? 8'h00 : {7'h00, lnk.din};
				end
			end
			ADSPS_SHIFT:
			begin
				if (lnk.cs_rise)
					r_nxt.state = ADSPS_IDLE;
				else
				begin
					// Only the first eight rising edges of a frame carry command bits.
					if (lnk.sclk_rise && r_r.bit_cnt < 5'(`ADSPS_CMD_BITS))
						r_nxt.cmd = {r_r.cmd[6:0], lnk.din};
					// Falling edges are counted so that the tenth one can be found.
					if (lnk.sclk_fall)
						r_nxt.bit_cnt = r_r.bit_cnt + 5'h01;
					// The shutdown decision is taken at the tenth falling edge only.
					if (tenth_fall && shut_code)
					begin
						r_nxt.state = ADSPS_DUMMY;
						r_nxt.powered = 1'b0;
						r_nxt.tick_cnt = 8'h00;
					end
					else if (lnk.sclk_fall && r_r.bit_cnt == 5'(FRAME_SCLKS - 1))
						r_nxt.state = ADSPS_IDLE;
				end
			end
			ADSPS_DUMMY:
			begin
				// Shift clocks are ignored until the dummy conversion ends.
				if (tick)
				begin
					r_nxt.tick_cnt = r_r.tick_cnt + 8'h01;
					if (r_r.tick_cnt == 8'(DUMMY_TICKS - 1))
						r_nxt.state = ADSPS_SLEEP;
				end
			end
		endcase
	end

	// The reset state is powered and idle, ready for a frame.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			r_r <= '{state: ADSPS_IDLE, powered: `ADSPS_POWERED_RST, default: '0};
		else
			r_r <= r_nxt;
	end

	// Busy and asleep are decoded from the state; the other outputs come straight from register bits.
	assign powered_up = r_r.powered;
	assign dummy_busy = (r_r.state == ADSPS_DUMMY);
	assign asleep = (r_r.state == ADSPS_SLEEP);
	assign conv_start = r_r.conv_start;
	assign cmd_word = r_r.cmd;

	////////////////////////////////////////////////////////////////////////////
	// The dummy conversion must fit inside the bound of its assertion.
	localparam int DUMMY_BOUND = 700;

	generate
		if (DUMMY_TICKS * ACLK_DIV >= DUMMY_BOUND)
			$error("dummy conversion too long for its check");
	endgenerate

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// Entry into and exit from shutdown, and requests while idle.
	a_tenth_edge_shut: assert property (r_r.state == ADSPS_SHIFT && !lnk.cs_rise && tenth_fall && shut_code
		|=> r_r.state == ADSPS_DUMMY && !powered_up) else $error("shutdown did not start at tenth edge");
	a_other_code_on: assert property (r_r.state == ADSPS_SHIFT && tenth_fall && !shut_code
		|=> powered_up && r_r.state != ADSPS_DUMMY) else $error("non-shutdown code powered down");
	a_fall_needs_code: assert property ($fell(powered_up)
		|-> $past(shut_code) && $past(r_r.bit_cnt) == 5'(`ADSPS_SHUTDOWN_EDGE - 1))
		else $error("power dropped without shutdown code");
	a_wake_cs_fall: assert property (asleep && lnk.cs_fall
		|=> powered_up && conv_start && r_r.state == ADSPS_SHIFT) else $error("chip select fall did not wake");
	a_wake_sclk: assert property (asleep && !lnk.cs_n && lnk.sclk_rise |=> powered_up && conv_start)
		else $error("resumed shift clocks did not wake");
	a_dummy_ends: assert property ($rose(dummy_busy) |-> ##[1:DUMMY_BOUND] asleep)
		else $error("dummy conversion did not end");
	a_dummy_deaf: assert property (dummy_busy && (lnk.sclk_fall || lnk.cs_fall) |=> !powered_up && !conv_start)
		else $error("link activity woke a dummy conversion");
	a_sleep_holds: assert property (asleep && !request |=> asleep ##0 !powered_up)
		else $error("left sleep without request");
	a_idle_request: assert property (r_r.state == ADSPS_IDLE && request |=> conv_start ##1 !conv_start)
		else $error("request not seen while idle");
	a_power_rise_req: assert property ($rose(powered_up) |-> $past(asleep) && $past(request))
		else $error("powered up without a request");
	a_dummy_entry: assert property ($rose(dummy_busy) |-> $past(r_r.state == ADSPS_SHIFT))
		else $error("dummy conversion not entered from a frame");
	a_sleep_entry: assert property ($rose(asleep) |-> $past(dummy_busy))
		else $error("asleep without a dummy conversion");

	// Power level in each state.
	a_shift_powered: assert property (r_r.state == ADSPS_SHIFT |-> powered_up)
		else $error("shifting while powered down");
	a_idle_powered: assert property (r_r.state == ADSPS_IDLE |-> powered_up)
		else $error("idle while powered down");
	a_dummy_unpowered: assert property (dummy_busy |-> !powered_up)
		else $error("dummy conversion while powered");
	a_sleep_unpowered: assert property (asleep |-> !powered_up)
		else $error("asleep while powered");

	// Conversion request pulse.
	a_conv_pulse: assert property (conv_start |=> !conv_start)
		else $error("conversion start held too long");
	a_start_needs_req: assert property (!request |=> !conv_start)
		else $error("conversion start without a request");
	a_start_shift: assert property (conv_start |-> r_r.state == ADSPS_SHIFT)
		else $error("conversion start outside a frame");
	a_frame_no_restart: assert property (r_r.state != ADSPS_IDLE && !asleep |=> !conv_start)
		else $error("conversion start inside a frame");

	// Frame handling.
	a_cs_rise_abort: assert property (r_r.state == ADSPS_SHIFT && lnk.cs_rise |=> r_r.state == ADSPS_IDLE)
		else $error("chip select rise did not end the frame");
	a_frame_end: assert property (r_r.state == ADSPS_SHIFT && lnk.sclk_fall && !shut_code
		&& r_r.bit_cnt == 5'(FRAME_SCLKS - 1) |=> r_r.state == ADSPS_IDLE) else $error("frame did not end");
	a_bit_limit: assert property (r_r.state == ADSPS_SHIFT |-> r_r.bit_cnt <= 5'(FRAME_SCLKS - 1))
		else $error("frame counter beyond frame length");
	a_cmd_full: assert property (r_r.state == ADSPS_SHIFT && r_r.bit_cnt >= 5'(`ADSPS_CMD_BITS)
		|=> $stable(cmd_word)) else $error("bits beyond the command word were shifted in");
	a_cmd_held: assert property (r_r.state == ADSPS_DUMMY || (asleep && !request) |=> $stable(cmd_word))
		else $error("command word changed while shut down");

	// Dummy conversion clock.
	a_tick_limit: assert property (dummy_busy |-> r_r.tick_cnt <= 8'(DUMMY_TICKS - 1))
		else $error("dummy tick count beyond its length");
	a_div_limit: assert property (r_r.div_cnt <= 8'(ACLK_DIV - 1))
		else $error("conversion clock divider out of range");

	c_shutdown: cover property ($rose(dummy_busy));
	c_wake_sclk: cover property (asleep && !lnk.cs_n && lnk.sclk_rise);
	c_wake_cs: cover property (asleep && lnk.cs_fall);
	c_normal_frame: cover property (r_r.state == ADSPS_SHIFT ##1 r_r.state == ADSPS_IDLE && powered_up);
	c_cs_abort: cover property (r_r.state == ADSPS_SHIFT && lnk.cs_rise);
endmodule // adsps_top
`default_nettype wire

// ==== hdl/adsps_cfg.svh ====
// Constants of the serial converter power shutdown control.
// Overview of operation
// - Word length select 0 then 1 requests shutdown.
// - Next conversion request powers up, no delay.
// - Request: chip select falls, or clocks resume.
// - Shutdown starts at tenth shift clock fall.
// - One dummy conversion, then idle until request.
// - Shift clocks after dummy conversion wake device.
`ifndef ADSPS_CFG_SVH
`define ADSPS_CFG_SVH
`define ADSPS_CMD_BITS 8
`define ADSPS_WL_HI_BIT 1
`define ADSPS_WL_LO_BIT 0
`define ADSPS_SHUTDOWN_WL 2'b01
`define ADSPS_SHUTDOWN_EDGE 10
`define ADSPS_FRAME_SCLKS 16
`define ADSPS_DUMMY_TICKS 12
`define ADSPS_ACLK_DIV 4
`define ADSPS_POWERED_RST 1'b1
`endif

// ==== hdl/adsps_pkg.sv ====
// Types of the serial converter power shutdown control.
package adsps_pkg;
	typedef enum logic [1:0] {
		ADSPS_IDLE = 2'b00,
		ADSPS_SHIFT = 2'b01,
		ADSPS_DUMMY = 2'b11,
		ADSPS_SLEEP = 2'b10
	} adsps_state_type;

	typedef struct packed {
		adsps_state_type state;
		logic [4:0] bit_cnt;
		logic [7:0] cmd;
		logic [7:0] div_cnt;
		logic [7:0] tick_cnt;
		logic powered;
		logic conv_start;
	} adsps_core_type;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic din_s1;
		logic din_s2;
	} adsps_sync_type;
endpackage

// ==== hdl/adsps_link_if.sv ====
// Sampled link events passed from the pin sampler to the core.
`timescale 1ns/10ps
`default_nettype none
interface adsps_link_if;
	logic cs_n;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic din;
	modport sampler (output cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, din);
	modport core (input cs_n, cs_fall, cs_rise, sclk_rise, sclk_fall, din);
endinterface
`default_nettype wire

// ==== hdl/adsps_link_sampler.sv ====
// Two-stage synchronisers and edge finders for the serial link pins.
`timescale 1ns/10ps
`default_nettype none
module adsps_link_sampler
	import adsps_pkg::*;
(
	input wire logic mclk, // System clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic cs_n_pin, // Chip select pin, active low.
	input wire logic sclk_pin, // Shift clock pin.
	input wire logic din_pin, // Serial command data pin.
	adsps_link_if.sampler lnk // Sampled events to the core.
);
	adsps_sync_type r_r;
	adsps_sync_type r_nxt;

	always_comb
	begin
		r_nxt = r_r;
		r_nxt.cs_s1 = cs_n_pin;
		r_nxt.cs_s2 = r_r.cs_s1;
		r_nxt.cs_s3 = r_r.cs_s2;
		r_nxt.sclk_s1 = sclk_pin;
		r_nxt.sclk_s2 = r_r.sclk_s1;
		r_nxt.sclk_s3 = r_r.sclk_s2;
		r_nxt.din_s1 = din_pin;
		r_nxt.din_s2 = r_r.din_s1;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			r_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, default: 1'b0};
		else
			r_r <= r_nxt;
	end

	// Edges are found between the second and third stages only.
	assign lnk.cs_n = r_r.cs_s2;
	assign lnk.cs_fall = r_r.cs_s3 & ~r_r.cs_s2;
	assign lnk.cs_rise = ~r_r.cs_s3 & r_r.cs_s2;
	assign lnk.sclk_rise = ~r_r.sclk_s3 & r_r.sclk_s2;
	assign lnk.sclk_fall = r_r.sclk_s3 & ~r_r.sclk_s2;
	assign lnk.din = r_r.din_s2;
endmodule // adsps_link_sampler
`default_nettype wire

// ==== tb/adsps_host.sv ====
// Host serial port model that shifts command words into the block.
`timescale 1ns/10ps
`default_nettype none
module adsps_host
(
	input wire logic mclk, // System clock.
	output logic cs_n, // Chip select, active low.
	output logic sclk, // Shift clock, idle low.
	output logic din // Command data, MSB first.
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Past the eighth bit the data line toggles so a stale value is never shifted in.
	task automatic send(input logic [7:0] cmd, input int n, input logic raise);
		@(posedge mclk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			din <= (i < 8) ? cmd[7 - i] : ~din;
			repeat (5) @(posedge mclk);
			sclk <= 1'b1;
			repeat (5) @(posedge mclk);
			sclk <= 1'b0;
		end
		if (raise)
		begin
			repeat (5) @(posedge mclk);
			cs_n <= 1'b1;
			din <= ~din;
		end
	endtask
endmodule // adsps_host
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the power shutdown control.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	wire logic cs_n;
	wire logic sclk;
	wire logic din;
	logic powered_up;
	logic dummy_busy;
	logic asleep;
	logic conv_start;
	logic [7:0] cmd_word;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int starts = 0;
	adsps_top #(.FRAME_SCLKS(16), .DUMMY_TICKS(2), .ACLK_DIV(2)) adsps_top_i (.mclk(mclk), .resetn(resetn),
		.cs_n(cs_n), .sclk(sclk), .din(din), .powered_up(powered_up), .dummy_busy(dummy_busy),
		.asleep(asleep), .conv_start(conv_start), .cmd_word(cmd_word));
	adsps_host host_i (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din));
	always #4 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (conv_start === 1'b1)
			starts++;
		if (cycles == 5000)
		begin
			num_errors++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic reset_values();
		wt(1);
		check({5'h00, dummy_busy, asleep, conv_start}, 8'h00);
		check(powered_up, 1'b1);
		check(cmd_word, 8'h00);
	endtask
	task automatic shut_ten();
		host_i.send(8'h3d, 10, 1'b0);
		wt(1);
		check(powered_up, 1'b1);
		wt(4);
		check(powered_up, 1'b0);
		check(dummy_busy, 1'b1);
		host_i.send(8'h00, 0, 1'b1);
		wt(8);
		check(asleep, 1'b1);
		check(cmd_word, 8'h3d);
	endtask
	task automatic wake_cs();
		int s;
		s = starts;
		fork
			host_i.send(8'h3e, 16, 1'b1);
			begin
				wt(7);
				check(powered_up, 1'b1);
				check(asleep, 1'b0);
			end
		join
		wt(8);
		check(8'(starts - s), 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			if (c != 1)
			begin
				host_i.send({6'b001111, 2'(c)}, 16, 1'b1);
				wt(8);
				check(powered_up, 1'b1);
				check(cmd_word, {6'b001111, 2'(c)});
			end
		end
	endtask
	task automatic abort_nine();
		host_i.send(8'h3d, 9, 1'b1);
		wt(10);
		check(powered_up, 1'b1);
		check(dummy_busy, 1'b0);
	endtask
	task automatic wake_sclk();
		int s;
		s = starts;
		host_i.send(8'h3d, 16, 1'b0);
		wt(8);
		check(powered_up, 1'b1);
		check(8'(starts - s), 8'h02);
		host_i.send(8'h00, 0, 1'b1);
		wt(2);
		host_i.send(8'h3d, 10, 1'b0);
		wt(15);
		check(asleep, 1'b1);
		host_i.send(8'h3e, 10, 1'b1);
		wt(8);
		check(powered_up, 1'b1);
		check(cmd_word, 8'h3e);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		reset_values();
		shut_ten();
		wake_cs();
		abort_nine();
		wake_sclk();
		close_out();
	end
endmodule // testbench
`default_nettype wire
